// ===== hw/acs_pkg.sv
/*
 * Constants shared by the conversion sequencer: register map, field
 * positions, reset values, sequencer states and timing figures.
 * Assumes a 250 MHz core clock.
 */
`default_nettype none
package acs_pkg;
    // Register byte offsets
    localparam logic [7:0] ACS_OFF_CTL   = 8'h00; // converter_control
    localparam logic [7:0] ACS_OFF_DLY   = 8'h04; // conversion_delay
    localparam logic [7:0] ACS_OFF_STAT  = 8'h08; // channel_done_flags
    localparam logic [7:0] ACS_OFF_OMASK = 8'h0C; // one-shot channel mask
    localparam logic [7:0] ACS_OFF_RMASK = 8'h10; // repeat channel mask
    localparam logic [7:0] ACS_OFF_IEN   = 8'h54; // interrupt enables
    // Control field positions
    localparam int ACS_B_EN    = 0;
    localparam int ACS_B_ONCE  = 1;
    localparam int ACS_B_RPT   = 2;
    localparam int ACS_B_RDONE = 6;
    localparam int ACS_B_ODONE = 7;
    // Interrupt enable positions
    localparam int ACS_B_IE_O  = 0;
    localparam int ACS_B_IE_R  = 1;
    // Reset values
    localparam logic [15:0] ACS_RST_16 = 16'h0000;
    localparam logic [1:0]  ACS_RST_IE = 2'h0;
    // AXI responses
    localparam logic [1:0] ACS_OKAY   = 2'h0;
    localparam logic [1:0] ACS_SLVERR = 2'h2;
    // Timing
    localparam int ACS_CLK_MHZ     = 250;
    localparam int ACS_CONV_NS     = 10000; // per channel, 10 us
    localparam int ACS_TICK_NS     = 40000; // delay unit, 40 us
    localparam int ACS_CONV_CYCLES = (ACS_CONV_NS * ACS_CLK_MHZ + 999) / 1000;
    localparam int ACS_TICK_CYCLES = (ACS_TICK_NS * ACS_CLK_MHZ + 999) / 1000;
    localparam int ACS_LAST_CHAN   = 15;
    // Sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_SCAN = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_e;
endpackage : acs_pkg
`default_nettype wire

// ===== hw/acs_sequencer.sv
/*
 * Conversion sequencer for a sixteen-channel converter core, with an
 * AXI4-Lite register slave. Assumes the converter core converts the
 * channel on conv_channel while conv_active is high, and that the
 * bus master keeps the AXI4-Lite rules.
 */
// What this block does
// R1 - Enable low keeps core down, no new cycles; core stays up until a running cycle drains
// R2 - Enable rising gives one-cycle core reset
// R3 - One-shot start begins cycle at once
// R4 - Each enabled channel converts for 10 us
// R5 - One-shot bit self-clears at start; 0 ignored
// R6 - One-shot waits behind running periodic cycle
// R7 - Repeat start loads start delay into timer
// R8 - Timer zero reloads repeat delay while enabled
// R9 - Periodic waits behind running one-shot cycle
// R10 - Repeat off clears timer, stops periodic cycles
// R11 - One-shot flag clears at start, sets at end
// R12 - Periodic flag clears at start, sets at end
// R13 - Both flags clear by writing one
// R14 - Each flag drives a gated interrupt
// R15 - Delays count 40 us steps, zero immediate
// R16 - Repeat delay spaces periodic cycles
// R17 - Delay fields never delay one-shot cycles
// R18 - Several expiries queue one periodic cycle
// R19 - Per-channel done bits, write-one clear
// R20 - Channels converted in ascending order
// R21 - Channel bit set on done, reset clears
// R22 - Fixed prescaler makes the 40 us tick
`default_nettype none
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int TICK_CYCLES = ACS_TICK_CYCLES // 40 us in clocks
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             conv_power_down,
    output logic             conv_reset,
    output logic [3:0]       conv_channel,
    output logic             conv_active,
    output logic             conv_done,
    output logic             oneshot_irq,
    output logic             periodic_irq
);
    // Lowest enabled channel at or above 'from'; 16 means none left
    function automatic logic [4:0] next_chan(input logic [15:0] m,
                                             input logic [4:0]  from);
        logic [4:0] r;
        r = 5'h10;
        for (int i = ACS_LAST_CHAN; i >= 0; i--) begin
            if (m[i] && (5'(i) >= from)) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : next_chan

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Bus side holding registers
    logic        aw_held;     // Write address taken
    logic        w_held;      // Write data taken
    logic [7:0]  wr_addr;     // Held write address
    logic [31:0] wr_data;     // Held write data
    logic [3:0]  wr_strb;     // Held strobes
    logic        wr_fire;     // Both halves present, do the write
    logic [31:0] wr_lanes;    // Strobe mask expanded to bits
    logic [31:0] w1c;         // Bits written as one on enabled lanes
    // Software visible state
    logic        ctl_en;            // Converter enable
    logic        start_once;        // One-shot request
    logic        rpt_on;            // Repeat start bit
    logic        oneshot_done_flag; // One-shot complete
    logic        periodic_done_flag;// Periodic complete
    logic [15:0] start_delay;       // Start delay, 40 us units
    logic [15:0] repeat_delay;      // Repeat delay, 40 us units
    logic [15:0] once_mask;         // One-shot channel mask
    logic [15:0] rpt_mask;          // Repeat channel mask
    logic [15:0] channel_done_bits; // Per-channel done
    logic [1:0]  irq_en;            // Interrupt enables
    // Sequencer
    acs_state_e  state;        // Sequencer state
    logic        kind_once;    // Running cycle is a one-shot
    logic [4:0]  scan_idx;     // First channel not yet examined
    logic [11:0] conv_cnt;     // Cycles spent on this channel
    logic [4:0]  nxt;          // Next channel found by the scan
    logic        cyc_start;    // A cycle begins this clock
    logic        cyc_end;      // A cycle ends this clock
    logic        ch_end;       // A channel finishes this clock
    logic        en_prev;      // Enable one clock ago
    // Repeat timer
    logic [15:0] rpt_cnt;      // Remaining 40 us units
    logic [13:0] pre_cnt;      // Prescaler toward one tick
    logic        rpt_pend;     // One periodic cycle queued
    logic        rpt_expire;   // Timer at zero this clock
    logic        ctl_wr;       // Write to control, low lane
    logic        rpt_wr1;      // Repeat bit written with one

    // Write decode
    assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
    assign wr_lanes = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                       {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign w1c      = wr_data & wr_lanes;
    assign ctl_wr   = wr_fire && (wr_addr == ACS_OFF_CTL) && wr_strb[0];
    assign rpt_wr1  = ctl_wr && wr_data[ACS_B_RPT];
    assign s_axi_awready = !aw_held;
    assign s_axi_wready  = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // Address and data may arrive in either order; each is held
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held) begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && !w_held) begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response; unmapped offsets answer SLVERR and store nothing
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= ACS_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (wr_addr)
                ACS_OFF_CTL, ACS_OFF_DLY, ACS_OFF_STAT, ACS_OFF_OMASK,
                ACS_OFF_RMASK, ACS_OFF_IEN: s_axi_bresp <= ACS_OKAY;
                default:                    s_axi_bresp <= ACS_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path; reserved bits read zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= ACS_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ACS_OKAY;
            case (s_axi_araddr)
                ACS_OFF_CTL:   s_axi_rdata <= {24'h00_0000, oneshot_done_flag,
                                   periodic_done_flag, 3'h0, rpt_on,
                                   start_once, ctl_en};
                ACS_OFF_DLY:   s_axi_rdata <= {repeat_delay, start_delay};
                ACS_OFF_STAT:  s_axi_rdata <= {16'h0000, channel_done_bits}; // R19
                ACS_OFF_OMASK: s_axi_rdata <= {16'h0000, once_mask};
                ACS_OFF_RMASK: s_axi_rdata <= {16'h0000, rpt_mask};
                ACS_OFF_IEN:   s_axi_rdata <= {30'h0000_0000, irq_en};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= ACS_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Plain read-write settings
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctl_en       <= 1'b0;
            start_delay  <= ACS_RST_16;
            repeat_delay <= ACS_RST_16;
            once_mask    <= ACS_RST_16;
            rpt_mask     <= ACS_RST_16;
            irq_en       <= ACS_RST_IE;
        end else if (wr_fire) begin
            if (ctl_wr) begin
                ctl_en <= wr_data[ACS_B_EN];
            end
            if (wr_addr == ACS_OFF_DLY) begin
                {repeat_delay, start_delay} <= merge({repeat_delay, start_delay},
                                                     wr_data, wr_strb);
            end
            if (wr_addr == ACS_OFF_OMASK) begin
                once_mask <= 16'(merge({16'h0000, once_mask}, wr_data, wr_strb));
            end
            if (wr_addr == ACS_OFF_RMASK) begin
                rpt_mask <= 16'(merge({16'h0000, rpt_mask}, wr_data, wr_strb));
            end
            if (wr_addr == ACS_OFF_IEN) begin
                irq_en <= 2'(merge({30'h0000_0000, irq_en}, wr_data, wr_strb));
            end
        end
    end

    // Start decision; one-shot wins when both wait
    assign cyc_start = (state == ACS_IDLE) && ctl_en && (start_once || rpt_pend); // R1
    assign nxt       = next_chan(kind_once ? once_mask : rpt_mask, scan_idx);
    assign ch_end    = (state == ACS_CONV) && (conv_cnt == 12'(ACS_CONV_CYCLES - 1));
    assign cyc_end   = (state == ACS_SCAN) && nxt[4];

    // One-shot request: a new write of one beats the self-clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            start_once <= 1'b0;
        end else if (ctl_wr && wr_data[ACS_B_ONCE]) begin
            start_once <= 1'b1; // R3
        end else if (cyc_start && start_once) begin
            start_once <= 1'b0; // R5
        end
    end

    // Sequencer; masks read live so unexamined channels see new values
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state        <= ACS_IDLE;
            kind_once    <= 1'b0;
            scan_idx     <= 5'h00;
            conv_cnt     <= 12'h000;
            conv_channel <= 4'h0;
        end else begin
            case (state)
                ACS_IDLE: begin
                    if (cyc_start) begin
                        kind_once <= start_once; // R6 R9 R17
                        scan_idx  <= 5'h00;
                        state     <= ACS_SCAN;
                    end
                end
                ACS_SCAN: begin
                    if (nxt[4]) begin
                        state <= ACS_IDLE;
                    end else begin
                        conv_channel <= nxt[3:0]; // R20
                        conv_cnt     <= 12'h000;
                        state        <= ACS_CONV;
                    end
                end
                ACS_CONV: begin
                    if (ch_end) begin
                        scan_idx <= 5'(conv_channel) + 5'h01; // R20
                        state    <= ACS_SCAN;
                    end else begin
                        conv_cnt <= conv_cnt + 12'h001; // R4
                    end
                end
                default: state <= ACS_IDLE;
            endcase
        end
    end

    // Core side strobes; power down waits for the cycle to drain
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            en_prev         <= 1'b0;
            conv_reset      <= 1'b0;
            conv_power_down <= 1'b1;
            conv_done       <= 1'b0;
        end else begin
            en_prev         <= ctl_en;
            conv_reset      <= ctl_en && !en_prev; // R2
            conv_power_down <= !ctl_en && (state == ACS_IDLE); // R1
            conv_done       <= ch_end;
        end
    end
    assign conv_active = (state == ACS_CONV);

    // Per-channel done bits; a set wins over a same-clock clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            channel_done_bits <= ACS_RST_16; // R21
        end else begin
            channel_done_bits <= (channel_done_bits
                & ~((wr_fire && wr_addr == ACS_OFF_STAT) ? w1c[15:0] : 16'h0000))
                | (ch_end ? (16'h0001 << conv_channel) : 16'h0000); // R19 R21
        end
    end

    // Completion flags; hardware set beats every clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            oneshot_done_flag  <= 1'b0;
            periodic_done_flag <= 1'b0;
        end else begin
            if (cyc_end && kind_once) begin
                oneshot_done_flag <= 1'b1; // R11
            end else if (cyc_start && start_once) begin
                oneshot_done_flag <= 1'b0; // R11
            end else if (ctl_wr && wr_data[ACS_B_ODONE]) begin
                oneshot_done_flag <= 1'b0; // R13
            end
            if (cyc_end && !kind_once) begin
                periodic_done_flag <= 1'b1; // R12
            end else if (cyc_start && !start_once) begin
                periodic_done_flag <= 1'b0; // R12
            end else if (ctl_wr && wr_data[ACS_B_RDONE]) begin
                periodic_done_flag <= 1'b0; // R13
            end
        end
    end
    assign oneshot_irq  = oneshot_done_flag && irq_en[ACS_B_IE_O];  // R14
    assign periodic_irq = periodic_done_flag && irq_en[ACS_B_IE_R]; // R14

    // Repeat timer; prescaler runs only while repeat is on and restarts on every control write to the low lane
    assign rpt_expire = rpt_on && (rpt_cnt == 16'h0000); // R15
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rpt_on  <= 1'b0;
            rpt_cnt <= 16'h0000;
            pre_cnt <= 14'h0000;
        end else if (ctl_wr && !wr_data[ACS_B_RPT]) begin
            rpt_on  <= 1'b0; // R10
            rpt_cnt <= 16'h0000;
            pre_cnt <= 14'h0000;
        end else if (rpt_wr1) begin
            rpt_on  <= 1'b1;
            rpt_cnt <= start_delay; // R7
            pre_cnt <= 14'h0000;
        end else if (rpt_expire) begin
            rpt_cnt <= repeat_delay; // R8 R16
            pre_cnt <= 14'h0000;
        end else if (rpt_on) begin
            if (pre_cnt == 14'(TICK_CYCLES - 1)) begin
                pre_cnt <= 14'h0000; // R22
                rpt_cnt <= rpt_cnt - 16'h0001; // R15
            end else begin
                pre_cnt <= pre_cnt + 14'h0001;
            end
        end
    end

    // Single pending periodic request; repeated expiries merge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rpt_pend <= 1'b0;
        end else if (!rpt_on || (ctl_wr && !wr_data[ACS_B_RPT])) begin
            rpt_pend <= 1'b0; // R10
        end else if (rpt_expire) begin
            rpt_pend <= 1'b1; // R18
        end else if (cyc_start && !start_once) begin
            rpt_pend <= 1'b0;
        end
    end

    // Helper: run length of one channel and last channel of the cycle
    logic [11:0] run_len;
    logic [4:0]  last_ch;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run_len <= 12'h000;
            last_ch <= 5'h10;
        end else begin
            run_len <= conv_active ? run_len + 12'h001 : 12'h000;
            if (cyc_start) begin
                last_ch <= 5'h10;
            end else if (ch_end) begin
                last_ch <= 5'(conv_channel);
            end
        end
    end

    chk_core_reset_pulse: assert property (@(posedge clock) disable iff (!nrst) // R2
        $rose(ctl_en) |=> conv_reset ##1 !conv_reset)
        else $error("core reset pulse not one cycle");
    chk_off_no_start: assert property (@(posedge clock) disable iff (!nrst) // R1
        (state == ACS_IDLE && !ctl_en) |=> state == ACS_IDLE)
        else $error("cycle began while disabled");
    chk_chan_conv_len: assert property (@(posedge clock) disable iff (!nrst) // R4
        $fell(conv_active) |-> $past(run_len) == 12'(ACS_CONV_CYCLES - 1))
        else $error("channel conversion length wrong");
    chk_chan_ascending: assert property (@(posedge clock) disable iff (!nrst) // R20
        ($rose(conv_active) && !last_ch[4]) |-> 5'(conv_channel) > last_ch)
        else $error("channels out of order");
    chk_once_self_clear: assert property (@(posedge clock) disable iff (!nrst) // R5
        (cyc_start && start_once && !ctl_wr) |=> !start_once && kind_once)
        else $error("one-shot bit not cleared at start");
    chk_once_flag_cycle: assert property (@(posedge clock) disable iff (!nrst) // R11
        (cyc_start && start_once) |=> !oneshot_done_flag ##1 (!oneshot_done_flag || $past(cyc_end)))
        else $error("one-shot flag not cleared at start");
    chk_flag_on_end: assert property (@(posedge clock) disable iff (!nrst) // R12
        (cyc_end && !kind_once) |=> periodic_done_flag && state == ACS_IDLE)
        else $error("periodic flag not set at end");
    chk_repeat_stop: assert property (@(posedge clock) disable iff (!nrst) // R10
        $fell(rpt_on) |-> rpt_cnt == 16'h0000 && !rpt_pend)
        else $error("repeat timer not cleared");
    chk_chan_bit_set: assert property (@(posedge clock) disable iff (!nrst) // R21
        conv_done |-> channel_done_bits[conv_channel])
        else $error("channel done bit missing");
    cov_once_cycle: cover property (@(posedge clock) disable iff (!nrst)
        cyc_end && kind_once);
    cov_periodic_cycle: cover property (@(posedge clock) disable iff (!nrst)
        cyc_end && !kind_once);
    cov_once_behind_rpt: cover property (@(posedge clock) disable iff (!nrst)
        (cyc_end && !kind_once && start_once) ##1 cyc_start);
endmodule : acs_sequencer
`default_nettype wire

// ===== dv/acs_core_model.sv
/*
 * Converter core model: logs the channel order, the length of each
 * conversion and the reset pulses it is given.
 * Assumes the sequencer drives all conv_* lines from the core clock.
 */
`default_nettype none
module acs_core_model (
    input wire logic       clock,
    input wire logic       conv_power_down,
    input wire logic       conv_reset,
    input wire logic [3:0] conv_channel,
    input wire logic       conv_active,
    input wire logic       conv_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] chans[$];   // Channels in the order converted
    int         lens[$];    // Clocks spent on each channel
    int         run = 0;    // Length of the stretch in progress
    int         resets = 0; // Clocks with reset high, so a long pulse shows
    int         dones = 0;  // Channel-finished pulses seen
    // One log entry per active stretch; stretches under power-down are not logged
    always @(posedge clock) begin
        if (conv_reset) begin
            resets <= resets + 1;
        end
        if (conv_done) begin
            dones <= dones + 1;
        end
        if (conv_active && !conv_power_down) begin
            if (run == 0) begin
                chans.push_back(conv_channel);
            end
            run <= run + 1;
        end else if (run != 0) begin
            lens.push_back(run);
            run <= 0;
        end
    end
endmodule : acs_core_model
`default_nettype wire

// ===== dv/acs_sequencer_tb.sv
/*
 * Self-checking bench for acs_sequencer: register rows, then cycle scheduling.
 * Assumes acs_core_model watches the core side; tick shortened to 10 clocks.
 */
`default_nettype none
module acs_sequencer_tb
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_power_down;
    logic        conv_reset, conv_active, conv_done, oneshot_irq, periodic_irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, q;
    logic [3:0]  s_axi_wstrb, conv_channel;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    int          errors = 0, checks_done = 0;
    // Rows: address, word written, word read back, response
    logic [7:0]  ta[5] = '{8'h04, 8'h0C, 8'h10, 8'h54, 8'h80};
    logic [31:0] td[5] = '{32'h0002_0001, 32'h5, 32'h8000, 32'h3, 32'h1};
    logic [31:0] tq[5] = '{32'h0002_0001, 32'h5, 32'h8000, 32'h3, 32'h0};
    logic [1:0]  tr[5] = '{ACS_OKAY, ACS_OKAY, ACS_OKAY, ACS_OKAY, ACS_SLVERR};
    logic [3:0]  ec[4] = '{4'hF, 4'h0, 4'h2, 4'hF}; // Expected channel order
    acs_sequencer #(.TICK_CYCLES(10)) acs_sequencer_i (.clock, .nrst, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .conv_power_down, .conv_reset, .conv_channel, .conv_active,
        .conv_done, .oneshot_irq, .periodic_irq);
    acs_core_model acs_core_model_i (.clock, .conv_power_down, .conv_reset,
        .conv_channel, .conv_active, .conv_done);
    task automatic print_verdict;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // A used-up bound is a hang: count it and close the run
    task automatic lim(input int n, input int m);
        if (n >= m) begin
            errors++;
            print_verdict();
        end
    endtask : lim
    // Write with both halves offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        lim(n, 100);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clock);
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 100);
        q = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        lim(n, 100);
    endtask : rd
    // Wait for conversion (0), one-shot interrupt (1) or periodic interrupt (2)
    task automatic wt(input int w, input int m);
        int n;
        n = 0;
        while (n < m && !(w == 0 ? conv_active : w == 1 ? oneshot_irq : periodic_irq)) begin
            @(posedge clock);
            n++;
        end
        lim(n, m);
    endtask : wt
    // Free-running 250 MHz core clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        nrst = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd(ACS_OFF_STAT);
        chk(q, 32'h0);
        chk(conv_power_down, 1'b1);
        // Register rows, unmapped place last
        for (int i = 0; i < 5; i++) begin
            wr(ta[i], td[i]);
            chk(r, tr[i]);
            rd(ta[i]);
            chk(q, tq[i]);
            chk(r, tr[i]);
        end
        // Enable and repeat; one-shot queued behind the first periodic cycle
        wr(ACS_OFF_CTL, 32'h5);
        // Start delay of one unit: the cycle must not begin before it runs out
        repeat (11) @(posedge clock);
        chk(conv_active, 1'b0);
        wt(0, 3);
        chk(acs_core_model_i.resets, 1);
        chk(conv_power_down, 1'b0);
        wr(ACS_OFF_CTL, 32'h7);
        wt(1, 12000);
        rd(ACS_OFF_CTL);
        chk(q, 32'h85);
        // Repeat off while the queued periodic cycle runs: it still finishes
        wr(ACS_OFF_CTL, 32'h1);
        wt(2, 6000);
        repeat (100) @(posedge clock);
        chk(conv_active, 1'b0);
        chk(acs_core_model_i.chans.size(), 4);
        foreach (ec[i]) chk(acs_core_model_i.chans[i], ec[i]);
        chk(acs_core_model_i.lens.size(), 4);
        foreach (acs_core_model_i.lens[i]) chk(acs_core_model_i.lens[i], ACS_CONV_CYCLES);
        chk(acs_core_model_i.dones, 4);
        rd(ACS_OFF_STAT);
        chk(q, 32'h8005);
        wr(ACS_OFF_STAT, 32'h1);
        rd(ACS_OFF_STAT);
        chk(q, 32'h8004);
        wr(ACS_OFF_CTL, 32'h41);
        rd(ACS_OFF_CTL);
        chk(q, 32'h81);
        chk(periodic_irq, 1'b0);
        wr(ACS_OFF_CTL, 32'h1);
        rd(ACS_OFF_CTL);
        chk(q, 32'h81);
        chk(oneshot_irq, 1'b1);
        wr(ACS_OFF_CTL, 32'h80);
        rd(ACS_OFF_CTL);
        chk(q, 32'h0);
        chk(conv_power_down, 1'b1);
        // Reset while idle and disabled: channel bits still standing must clear
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd(ACS_OFF_STAT);
        chk(q, 32'h0);
        print_verdict();
    end
endmodule : acs_sequencer_tb
`default_nettype wire
